// *** mqf_defs.svh ***
// constants and behaviour summary for the active queue flag logic
// What this block does
// - empty flag floats when no own queue read-selected
// - top three read address bits match device id
// - same-device reselect keeps driving, updates status
// - almost-full pin shows write-selected queue only
// - offsets programmed or defaulted to 8/128
// - almost-full offset per queue, zero to depth
// - almost-full shows new queue third write edge
// - almost-full falls three cycles after write
// - read clears almost-full after one cycle
// - skew violation adds one write cycle
// - almost-full changes only on write clock edge
// - reads update internal almost-full of any queue
// - almost-empty pin shows read-selected queue only
// - almost-empty offset per queue, zero to depth
// - almost-empty shows new queue third read edge
// - almost-empty falls three cycles after read
// - write clears almost-empty after one cycle
// - skew violation adds one read cycle
// - almost-empty changes only on read clock edge
// - writes update internal almost-empty of any queue
`ifndef MQF_DEFS_SVH
`define MQF_DEFS_SVH

// default port geometry
`define MQF_ADDR_W 8
`define MQF_ID_BITS 3
`define MQF_DEPTH 512

// default offsets chosen by default programming
`define MQF_DFLT_OFF_SMALL 8
`define MQF_DFLT_OFF_LARGE 128

// offset held by every queue out of reset
`define MQF_RST_OFF 8

// edges from queue selection to flag showing the new queue
`define MQF_SEL_LATENCY 3

`endif

// *** mqf_pkg.sv ***
// types shared by the active queue flag logic
package mqf_pkg;

  // which default offset default programming loads
  typedef enum logic [0:0] {
    MQF_DFLT_SMALL = 1'h0,
    MQF_DFLT_LARGE = 1'h1
  } mqf_dflt_e;

endpackage : mqf_pkg

// *** mqf_queue_sel.sv ***
// queue selection pipeline with device id match for one port
`timescale 1ns/100ps
`default_nettype none
`include "mqf_defs.svh"
module mqf_queue_sel
  import mqf_pkg::*;
#(
  parameter int ADDR_W = `MQF_ADDR_W,
  parameter int ID_BITS = `MQF_ID_BITS,
  localparam int QW = ADDR_W - ID_BITS
) (
  // clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // selection strobe and address
  input wire logic sel_en,
  input wire logic [ADDR_W-1:0] sel_addr,
  input wire logic [2:0] dev_id,
  // selection two edges old, about to take over
  output logic pend_load,
  output logic [QW-1:0] pend_q,
  output logic pend_mine,
  // queue currently in force on this port
  output logic [QW-1:0] active_q,
  output logic active_mine
);

  ////////////////////////////////////////////////////////////////////////
  // id compare on the address high bits
  wire logic id_match;
  assign id_match = sel_addr[ADDR_W-1 -: ID_BITS] == dev_id[ID_BITS-1:0];

  // pipeline stages
  logic s1_v_reg, s2_v_reg; // selection seen one and two edges ago
  logic [QW-1:0] s1_q_reg, s2_q_reg, act_q_reg;
  logic s1_m_reg, s2_m_reg, act_m_reg;

  ////////////////////////////////////////////////////////////////////////
  // shift the selection along; a third-edge takeover lets the flag
  // show the new queue on the same edge as its first data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_v_reg <= 1'h0;
      s2_v_reg <= 1'h0;
      s1_q_reg <= '0;
      s2_q_reg <= '0;
      s1_m_reg <= 1'h0;
      s2_m_reg <= 1'h0;
    end else begin
      s1_v_reg <= sel_en;
      s1_q_reg <= sel_addr[QW-1:0];
      s1_m_reg <= id_match;
      s2_v_reg <= s1_v_reg;
      s2_q_reg <= s1_q_reg;
      s2_m_reg <= s1_m_reg;
    end
  end

  // active queue; held between selections so ownership sticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q_reg <= '0;
      act_m_reg <= 1'h0; // nothing selected: not ours
    end else if (s2_v_reg) begin
      act_q_reg <= s2_q_reg;
      act_m_reg <= s2_m_reg;
    end
  end

  assign pend_load = s2_v_reg;
  assign pend_q = s2_q_reg;
  assign pend_mine = s2_m_reg;
  assign active_q = act_q_reg;
  assign active_mine = act_m_reg;

endmodule : mqf_queue_sel
`default_nettype wire

// *** mqf_flag_pipe.sv ***
// double register buffered active flag with fast release path
`timescale 1ns/100ps
`default_nettype none
`include "mqf_defs.svh"
module mqf_flag_pipe
  import mqf_pkg::*;
(
  // clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // live condition of the active queue
  input wire logic live,
  // queue switch: preload the pipe with the new queue
  input wire logic pend_load,
  input wire logic pend_val,
  // other port misses its skew window
  input wire logic skew_late,
  // flag, low while condition holds
  output logic flag_n
);

  logic d1_reg, d2_reg; // two buffer stages
  wire logic release_src; // path that lets the flag go high

  ////////////////////////////////////////////////////////////////////////
  // releasing comes from the other port, so it skips the buffer; one
  // extra stage models a missed skew window
  assign release_src = skew_late ? d1_reg : live;

  // buffer stages; a switch loads both so no stale queue leaks out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d1_reg <= 1'h0;
      d2_reg <= 1'h0;
    end else if (pend_load) begin
      d1_reg <= pend_val;
      d2_reg <= pend_val;
    end else begin
      d1_reg <= live;
      d2_reg <= d1_reg;
    end
  end

  // output flop: asserting waits for the buffer, releasing skips it unless skew_late
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_n <= 1'h1; // condition absent
    end else begin
      flag_n <= ~(d2_reg & release_src);
    end
  end

endmodule : mqf_flag_pipe
`default_nettype wire

// *** mqf_active_flags.sv ***
// active queue empty, almost-full and almost-empty flag logic
`timescale 1ns/100ps
`default_nettype none
`include "mqf_defs.svh"
module mqf_active_flags
  import mqf_pkg::*;
#(
  parameter int ADDR_W = `MQF_ADDR_W,
  parameter int ID_BITS = `MQF_ID_BITS,
  parameter int DEPTH = `MQF_DEPTH,
  localparam int QW = ADDR_W - ID_BITS,
  localparam int NUM_Q = 1 << QW,
  localparam int CW = $clog2(DEPTH + 1)
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // static device identity
  input wire logic device_id_bit0,
  input wire logic device_id_bit1,
  input wire logic device_id_bit2,
  // write port
  input wire logic [ADDR_W-1:0] write_queue_addr,
  input wire logic write_addr_enable,
  input wire logic write_enable_n,
  // read port
  input wire logic [ADDR_W-1:0] read_queue_addr,
  input wire logic read_addr_enable,
  input wire logic read_enable_n,
  // static skew status of each port against the other
  input wire logic rd_to_wr_skew_late,
  input wire logic wr_to_rd_skew_late,
  // offset programming
  input wire logic prog_en,
  input wire logic [QW-1:0] prog_queue,
  input wire logic [CW-1:0] prog_paf_offset,
  input wire logic [CW-1:0] prog_pae_offset,
  input wire logic default_load,
  input wire logic default_sel,
  // active flags
  output logic almost_full_flag_n,
  output logic almost_empty_flag_n,
  output logic empty_flag_n,
  output logic empty_flag_oe_n
);

  ////////////////////////////////////////////////////////////////////////
  // parameter checks
  if (ID_BITS < 1 || ID_BITS > 3) begin : g_bad_id
    $error("id width must be 1 to 3");
  end
  if (ADDR_W - ID_BITS < 1 || ADDR_W > 16) begin : g_bad_addr
    $error("address width cannot hold id and queue bits");
  end
  if (DEPTH < `MQF_DFLT_OFF_LARGE) begin : g_bad_depth
    $error("queue depth below the largest default offset");
  end

  ////////////////////////////////////////////////////////////////////////
  // constants at counter width
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] OFF_SMALL = CW'(`MQF_DFLT_OFF_SMALL);
  localparam logic [CW-1:0] OFF_LARGE = CW'(`MQF_DFLT_OFF_LARGE);
  localparam logic [CW-1:0] OFF_RST = CW'(`MQF_RST_OFF);

  ////////////////////////////////////////////////////////////////////////
  // reset release: asserted at once, removed after two edges
  logic rst_meta_reg; // first stage, read only by the second
  logic rst_sync_reg; // reset used by the rest of the block

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'h0;
      rst_sync_reg <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // device identity as one bus
  wire logic [2:0] dev_id;
  assign dev_id = {device_id_bit2, device_id_bit1, device_id_bit0};

  // write port selection
  wire logic wr_pend_load; // write switch takes over this edge
  wire logic [QW-1:0] wr_pend_q; // queue taking over
  wire logic wr_pend_mine; // it belongs to this device
  wire logic [QW-1:0] wr_q; // active write queue
  wire logic wr_mine; // active write queue is ours

  mqf_queue_sel #(
    .ADDR_W(ADDR_W),
    .ID_BITS(ID_BITS)
  ) u_wr_sel (
    .clk(sys_clk),
    .rst_n(rst_sync_reg),
    .sel_en(write_addr_enable),
    .sel_addr(write_queue_addr),
    .dev_id(dev_id),
    .pend_load(wr_pend_load),
    .pend_q(wr_pend_q),
    .pend_mine(wr_pend_mine),
    .active_q(wr_q),
    .active_mine(wr_mine)
  );

  // read port selection
  wire logic rd_pend_load; // read switch takes over this edge
  wire logic [QW-1:0] rd_pend_q; // queue taking over
  wire logic rd_pend_mine; // it belongs to this device
  wire logic [QW-1:0] rd_q; // active read queue
  wire logic rd_mine; // active read queue is ours

  mqf_queue_sel #(
    .ADDR_W(ADDR_W),
    .ID_BITS(ID_BITS)
  ) u_rd_sel (
    .clk(sys_clk),
    .rst_n(rst_sync_reg),
    .sel_en(read_addr_enable),
    .sel_addr(read_queue_addr),
    .dev_id(dev_id),
    .pend_load(rd_pend_load),
    .pend_q(rd_pend_q),
    .pend_mine(rd_pend_mine),
    .active_q(rd_q),
    .active_mine(rd_mine)
  );

  ////////////////////////////////////////////////////////////////////////
  // per queue status vectors
  logic [NUM_Q-1:0] full_vec; // queue holds its whole depth
  logic [NUM_Q-1:0] empty_vec; // queue holds nothing
  logic [NUM_Q-1:0] af_vec; // at or past almost-full boundary
  logic [NUM_Q-1:0] ae_vec; // at or below almost-empty boundary

  // accepted operations; overflow and underflow are dropped
  wire logic wr_go;
  wire logic rd_go;
  assign wr_go = ~write_enable_n & wr_mine & ~full_vec[wr_q];
  assign rd_go = ~read_enable_n & rd_mine & ~empty_vec[rd_q];

  // default offset picked by default programming
  wire logic [CW-1:0] dflt_off;
  assign dflt_off = (default_sel == MQF_DFLT_LARGE) ? OFF_LARGE : OFF_SMALL;

  // offsets above the depth are clamped to the depth
  wire logic [CW-1:0] paf_prog_c;
  wire logic [CW-1:0] pae_prog_c;
  assign paf_prog_c = (prog_paf_offset > DEPTH_C) ? DEPTH_C : prog_paf_offset;
  assign pae_prog_c = (prog_pae_offset > DEPTH_C) ? DEPTH_C : prog_pae_offset;

  ////////////////////////////////////////////////////////////////////////
  // one fill counter and offset pair per queue; every queue tracks
  // its own status whether or not it is on a flag pin
  for (genvar q = 0; q < NUM_Q; q++) begin : g_queue
    logic [CW-1:0] cnt_reg; // words held
    logic [CW-1:0] cnt_next;
    logic [CW-1:0] paf_off_reg; // free words at which almost full
    logic [CW-1:0] pae_off_reg; // words at which almost empty
    wire logic wr_hit;
    wire logic rd_hit;
    wire logic prog_hit;

    assign wr_hit = wr_go & (wr_q == QW'(q));
    assign rd_hit = rd_go & (rd_q == QW'(q));
    assign prog_hit = prog_en & (prog_queue == QW'(q));

    // both ports on one queue in one edge leave the count alone
    assign cnt_next = (wr_hit & ~rd_hit) ? cnt_reg + CW'(1) :
                      (rd_hit & ~wr_hit) ? cnt_reg - CW'(1) : cnt_reg;

    // fill counter
    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
        cnt_reg <= '0;
      end else begin
        cnt_reg <= cnt_next;
      end
    end

    // offsets: default load wins over a single-queue write
    always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
        paf_off_reg <= OFF_RST;
        pae_off_reg <= OFF_RST;
      end else if (default_load) begin
        paf_off_reg <= dflt_off;
        pae_off_reg <= dflt_off;
      end else if (prog_hit) begin
        paf_off_reg <= paf_prog_c;
        pae_off_reg <= pae_prog_c;
      end
    end

    // status decode
    assign full_vec[q] = cnt_reg == DEPTH_C;
    assign empty_vec[q] = cnt_reg == '0;
    assign af_vec[q] = cnt_reg >= (DEPTH_C - paf_off_reg);
    assign ae_vec[q] = cnt_reg <= pae_off_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // conditions of the active and the incoming queue on each port;
  // a foreign queue reads as condition absent
  wire logic af_live, af_pend;
  wire logic ae_live, ae_pend;
  wire logic em_live, em_pend;
  assign af_live = wr_mine & af_vec[wr_q];
  assign af_pend = wr_pend_mine & af_vec[wr_pend_q];
  assign ae_live = rd_mine & ae_vec[rd_q];
  assign ae_pend = rd_pend_mine & ae_vec[rd_pend_q];
  assign em_live = rd_mine & empty_vec[rd_q];
  assign em_pend = rd_pend_mine & empty_vec[rd_pend_q];

  // almost-full flag on the write side
  mqf_flag_pipe u_paf (
    .clk(sys_clk),
    .rst_n(rst_sync_reg),
    .live(af_live),
    .pend_load(wr_pend_load),
    .pend_val(af_pend),
    .skew_late(rd_to_wr_skew_late),
    .flag_n(almost_full_flag_n)
  );

  // almost-empty flag on the read side
  mqf_flag_pipe u_pae (
    .clk(sys_clk),
    .rst_n(rst_sync_reg),
    .live(ae_live),
    .pend_load(rd_pend_load),
    .pend_val(ae_pend),
    .skew_late(wr_to_rd_skew_late),
    .flag_n(almost_empty_flag_n)
  );

  // empty flag shares the read side timing
  mqf_flag_pipe u_ef (
    .clk(sys_clk),
    .rst_n(rst_sync_reg),
    .live(em_live),
    .pend_load(rd_pend_load),
    .pend_val(em_pend),
    .skew_late(wr_to_rd_skew_late),
    .flag_n(empty_flag_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // empty flag drive: only the device owning the read queue drives
  // the shared wire; the controller keeps reads on one device at a
  // time, so two drivers never meet while selections are honest
  always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      empty_flag_oe_n <= 1'h1; // floating until selected
    end else begin
      empty_flag_oe_n <= ~rd_mine;
    end
  end

endmodule : mqf_active_flags
`default_nettype wire

// *** mqf_ctrl_model.sv ***
// controller side of the shared empty flag line
`timescale 1ns/100ps
`default_nettype none
module mqf_ctrl_model (
  // device pins
  input wire logic ef_n,
  input wire logic ef_oe_n,
  // level the controller samples
  output logic bus_ef_n
);
  // pull-up holds the line high when no device drives it
  // bench reads one device only, so one driver at most
  assign bus_ef_n = ef_oe_n ? 1'b1 : ef_n;
endmodule : mqf_ctrl_model
`default_nettype wire

// *** mqf_active_flags_monitor.sv ***
// concurrent checks on the active queue flag outputs
`timescale 1ns/100ps
`default_nettype none
module mqf_active_flags_monitor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // identity and port controls
  input wire logic device_id_bit0,
  input wire logic device_id_bit1,
  input wire logic device_id_bit2,
  input wire logic [7:0] read_queue_addr,
  input wire logic write_addr_enable,
  input wire logic write_enable_n,
  input wire logic read_addr_enable,
  input wire logic read_enable_n,
  input wire logic rd_to_wr_skew_late,
  input wire logic wr_to_rd_skew_late,
  input wire logic prog_en,
  input wire logic default_load,
  // flags
  input wire logic almost_full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic empty_flag_n,
  input wire logic empty_flag_oe_n
);
  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  // offset changes move flags too, so flag checks skip them
  logic [2:0] prog_age_reg;
  logic [2:0] prog_age_next;
  logic id_hit;  // read selection names this device
  logic settled;  // no offset change in flight
  assign id_hit = read_queue_addr[7:5] ==
    {device_id_bit2, device_id_bit1, device_id_bit0};
  assign settled = prog_age_reg == 3'h7;
  assign prog_age_next = (prog_en || default_load) ? 3'h0 :
    prog_age_reg + {2'h0, !settled};
  // saturating age counter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_age_reg <= 3'h0;
    end else begin
      prog_age_reg <= prog_age_next;
    end
  end
  ////////////////////////////////////////
  // no read selection for four edges
  sequence rd_quiet;
    (!read_addr_enable) [*4];
  endsequence
  // nothing on either port that moves the write flag
  sequence wr_quiet;
    (!write_addr_enable && write_enable_n && read_enable_n && settled) [*4];
  endsequence
  a_oe_hold_sel: assert property (rd_quiet |=> $stable(empty_flag_oe_n))
    else $error("empty flag drive changed without a selection");
  a_oe_owner_drive: assert property (read_addr_enable && id_hit |->
    ##4 !empty_flag_oe_n) else $error("own queue selected, flag not driven");
  a_oe_foreign_float: assert property (read_addr_enable && !id_hit |->
    ##4 empty_flag_oe_n) else $error("foreign queue selected, flag driven");
  a_ef_released_high: assert property (empty_flag_oe_n |-> empty_flag_n)
    else $error("empty flag low while released");
  a_paf_fall_cause: assert property ($fell(almost_full_flag_n) && settled |->
    $past(!write_enable_n, 4) || $past(write_addr_enable, 4))
    else $error("almost full fell without a write three edges back");
  a_paf_rise_cause: assert property ($rose(almost_full_flag_n) && settled |->
    $past(write_addr_enable, 4) || (rd_to_wr_skew_late ?
    $past(!read_enable_n, 3) : $past(!read_enable_n, 2)))
    else $error("almost full rose at the wrong distance from a read");
  a_pae_fall_cause: assert property ($fell(almost_empty_flag_n) && settled |->
    $past(!read_enable_n, 4) || $past(read_addr_enable, 4))
    else $error("almost empty fell without a read three edges back");
  a_pae_rise_cause: assert property ($rose(almost_empty_flag_n) && settled |->
    $past(read_addr_enable, 4) || (wr_to_rd_skew_late ?
    $past(!write_enable_n, 3) : $past(!write_enable_n, 2)))
    else $error("almost empty rose at the wrong distance from a write");
  a_paf_quiet_hold: assert property (wr_quiet |=>
    $stable(almost_full_flag_n)) else $error("almost full moved while idle");
endmodule : mqf_active_flags_monitor
`default_nettype wire

// *** tb_multiqueue_active_flag_logic.sv ***
// self-checking bench for the active queue flag logic
`timescale 1ns/100ps
`default_nettype none
module tb_multiqueue_active_flag_logic;
  import mqf_pkg::*;
  ////////////////////////////////////////
  // stimulus, all idle at time zero
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] dev_id = 3'h5;  // identity of the device under test
  logic [7:0] write_queue_addr = 8'h00, read_queue_addr = 8'h00;
  logic write_addr_enable = 1'b0, write_enable_n = 1'b1;
  logic read_addr_enable = 1'b0, read_enable_n = 1'b1;
  logic rd_to_wr_skew_late = 1'b0, wr_to_rd_skew_late = 1'b0;
  logic prog_en = 1'b0, default_load = 1'b0, default_sel = 1'b0;
  logic [4:0] prog_queue = 5'h00;
  logic [9:0] prog_paf_offset = 10'h000, prog_pae_offset = 10'h000;
  // outputs
  logic almost_full_flag_n, almost_empty_flag_n, empty_flag_n;
  logic empty_flag_oe_n, bus_ef_n;
  int miscompares = 0, checked = 0;
  // read selections: address, oe_n, empty, almost empty (all queues empty)
  logic [10:0] rows [5] = '{{8'ha0, 3'b000}, {8'h21, 3'b111},
    {8'he1, 3'b111}, {8'ha2, 3'b000}, {8'ha1, 3'b000}};
  always #2 sys_clk = ~sys_clk;
  mqf_active_flags dut_u (.sys_clk(sys_clk), .arst_n(arst_n),
    .device_id_bit0(dev_id[0]), .device_id_bit1(dev_id[1]),
    .device_id_bit2(dev_id[2]), .write_queue_addr(write_queue_addr),
    .write_addr_enable(write_addr_enable), .write_enable_n(write_enable_n),
    .read_queue_addr(read_queue_addr), .read_addr_enable(read_addr_enable),
    .read_enable_n(read_enable_n), .rd_to_wr_skew_late(rd_to_wr_skew_late),
    .wr_to_rd_skew_late(wr_to_rd_skew_late), .prog_en(prog_en),
    .prog_queue(prog_queue), .prog_paf_offset(prog_paf_offset),
    .prog_pae_offset(prog_pae_offset), .default_load(default_load),
    .default_sel(default_sel), .almost_full_flag_n(almost_full_flag_n),
    .almost_empty_flag_n(almost_empty_flag_n), .empty_flag_n(empty_flag_n),
    .empty_flag_oe_n(empty_flag_oe_n));
  mqf_ctrl_model ctrl_u (.ef_n(empty_flag_n), .ef_oe_n(empty_flag_oe_n),
    .bus_ef_n(bus_ef_n));
  ////////////////////////////////////////
  // compare one flag
  task automatic check(input string what, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  // advance n edges, land just after the last
  task automatic step(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      #1;
    end
  endtask : step
  task automatic sel_wr(input logic [7:0] a);
    write_queue_addr = a;
    write_addr_enable = 1'b1;
    step(1);
    write_addr_enable = 1'b0;
  endtask : sel_wr
  task automatic sel_rd(input logic [7:0] a);
    read_queue_addr = a;
    read_addr_enable = 1'b1;
    step(1);
    read_addr_enable = 1'b0;
  endtask : sel_rd
  // n back-to-back words
  task automatic wr(input int n);
    write_enable_n = 1'b0;
    step(n);
    write_enable_n = 1'b1;
  endtask : wr
  task automatic rd(input int n);
    read_enable_n = 1'b0;
    step(n);
    read_enable_n = 1'b1;
  endtask : rd
  task automatic dflt(input logic s);
    default_sel = s;
    default_load = 1'b1;
    step(1);
    default_load = 1'b0;
  endtask : dflt
  task automatic finish_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////
  // main sequence
  initial begin : main
    logic prev_oe;
    prev_oe = 1'b1;
    step(3);
    arst_n = 1'b1;
    step(3);
    check("reset paf", almost_full_flag_n, 1'b1);
    check("reset pae", almost_empty_flag_n, 1'b1);
    check("reset oe_n", empty_flag_oe_n, 1'b1);
    // queue 1: almost full at three words, almost empty at two or less
    prog_queue = 5'h01;
    prog_paf_offset = 10'h1fd;
    prog_pae_offset = 10'h002;
    prog_en = 1'b1;
    step(1);
    prog_en = 1'b0;
    // read selections across own and foreign devices
    foreach (rows[i]) begin
      sel_rd(rows[i][10:3]);
      step(2);
      check("oe_n before switch", empty_flag_oe_n, prev_oe);
      step(1);
      check("oe_n", empty_flag_oe_n, rows[i][2]);
      check("empty line", bus_ef_n, rows[i][1]);
      check("almost empty", almost_empty_flag_n, rows[i][0]);
      step(3);
      check("oe_n held", empty_flag_oe_n, rows[i][2]);
      prev_oe = rows[i][2];
    end
    // fill queue 1 to its almost full mark
    sel_wr(8'ha1);
    step(3);
    check("paf new queue", almost_full_flag_n, 1'b1);
    wr(2);
    step(3);
    check("paf below mark", almost_full_flag_n, 1'b1);
    wr(1);
    check("pae before release", almost_empty_flag_n, 1'b0);
    step(1);
    check("pae release", almost_empty_flag_n, 1'b1);
    step(1);
    check("paf not early", almost_full_flag_n, 1'b1);
    step(1);
    check("paf set", almost_full_flag_n, 1'b0);
    rd(1);
    check("paf before release", almost_full_flag_n, 1'b0);
    step(1);
    check("paf release", almost_full_flag_n, 1'b1);
    step(1);
    check("pae not early", almost_empty_flag_n, 1'b1);
    step(1);
    check("pae set", almost_empty_flag_n, 1'b0);
    // both skew windows missed: releases one edge later
    rd_to_wr_skew_late = 1'b1;
    wr_to_rd_skew_late = 1'b1;
    wr(1);
    step(1);
    check("pae late hold", almost_empty_flag_n, 1'b0);
    step(1);
    check("pae late release", almost_empty_flag_n, 1'b1);
    step(1);
    rd(1);
    step(1);
    check("paf late hold", almost_full_flag_n, 1'b0);
    step(1);
    check("paf late release", almost_full_flag_n, 1'b1);
    // keep the skew inputs one more edge: the release is judged with them
    step(1);
    rd_to_wr_skew_late = 1'b0;
    wr_to_rd_skew_late = 1'b0;
    step(1);
    // queue 1 back at three words, then switch write port away
    wr(1);
    step(3);
    sel_wr(8'ha2);
    step(2);
    check("paf old queue", almost_full_flag_n, 1'b0);
    step(1);
    check("paf switched", almost_full_flag_n, 1'b1);
    // switch read port to empty queue 0
    sel_rd(8'ha0);
    step(2);
    check("empty old queue", bus_ef_n, 1'b1);
    check("pae old queue", almost_empty_flag_n, 1'b1);
    step(1);
    check("empty switched", bus_ef_n, 1'b0);
    check("pae switched", almost_empty_flag_n, 1'b0);
    // both default offsets on queue 1 holding nine words
    sel_rd(8'ha1);
    sel_wr(8'ha1);
    dflt(1'b0);
    step(2);
    wr(6);
    step(4);
    check("pae small default", almost_empty_flag_n, 1'b1);
    dflt(1'b1);
    step(5);
    check("pae large default", almost_empty_flag_n, 1'b0);
    finish_test();
  end
  // watchdog: the sequence needs well under a thousand cycles
  initial begin : watchdog
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end
endmodule : tb_multiqueue_active_flag_logic
bind mqf_active_flags mqf_active_flags_monitor mon_u (.sys_clk(sys_clk),
  .arst_n(arst_n), .device_id_bit0(device_id_bit0),
  .device_id_bit1(device_id_bit1), .device_id_bit2(device_id_bit2),
  .read_queue_addr(read_queue_addr), .write_addr_enable(write_addr_enable),
  .write_enable_n(write_enable_n), .read_addr_enable(read_addr_enable),
  .read_enable_n(read_enable_n), .rd_to_wr_skew_late(rd_to_wr_skew_late),
  .wr_to_rd_skew_late(wr_to_rd_skew_late), .prog_en(prog_en),
  .default_load(default_load), .almost_full_flag_n(almost_full_flag_n),
  .almost_empty_flag_n(almost_empty_flag_n), .empty_flag_n(empty_flag_n),
  .empty_flag_oe_n(empty_flag_oe_n));
`default_nettype wire
